// ---- design/spi_status_data_core.sv ----
// Purpose: byte-wide serial port with status flags and shared data address
// Assumes: classic Wishbone slave, one bus clock, pins synchronised here
// Notes: bytes shift msb first; the serial clock is made only in master mode
//
// How it works
// - master serial clock is bus clock over (prescale+1) times 2^(power+1)
// - all prescale and power bits set gives the largest divisor, 2048
// - status reads any time; writes to status change nothing
// - receive-complete, status bit 7, sets when a byte lands in data
// - receive-complete clears on status read seeing it, then data read
// - transmit-empty, status bit 5, clears on status read then data write
// - a data write without that armed status read is thrown away
// - conflict flag, bit 4, sets on select low while master and enabled
// - conflict flag clears on status read seeing it, then control write
// - a conflict drops master select, disables outputs, aborts transfer
// - master starts a queued byte right after the previous one ends
// - unserviced receive flag drops later bytes, keeps the first
// - port enable hands all four pins to the serial port
// - each transfer rotates the 16-bit ring eight places
// - one address: reads give receive buffer, writes load transmit buffer
// - polarity only inverts the serial clock
// - phase picks sampling on odd or on even clock edges
// - master while master select is one, slave while zero
// - master rate field changes abort the transfer and go idle

`timescale 1ns/1ns
`default_nettype none

module spi_status_data_core
  import spi_core_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic ss_n_i,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic ss_m, ss_s;
  logic sck_m, sck_s, sck_d;
  logic mosi_m, mosi_s;
  logic miso_m, miso_s;

  // two flops per pin, sck adds a third for edge detection; the first flop is never read by logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ss_m <= 1'b1;
      ss_s <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
      miso_m <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      ss_m <= ss_n_i;
      ss_s <= ss_m;
      sck_m <= sck_i;
      sck_s <= sck_m;
      sck_d <= sck_s;
      mosi_m <= mosi_i;
      mosi_s <= mosi_m;
      miso_m <= miso_i;
      miso_s <= miso_m;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and bus decode

  logic [7:0] ctrl1, ctrl2, rate;
  logic [7:0] tx_buf, rx_buf;
  logic rx_flag, tx_empty, conflict_flag;
  logic rx_armed, tx_armed, conflict_armed;
  logic req, wr, rd;
  logic hit_ctrl1, hit_ctrl2, hit_rate, hit_status, hit_data;
  logic port_en, master, clock_polarity_bit, clock_phase_bit, conflict_en, irq_en;
  logic [RATE_FIELD_W-1:0] prescale, power;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i && sel_i[0];
  assign rd = req && !we_i;
  assign hit_ctrl1 = adr_i == OFS_CTRL1;
  assign hit_ctrl2 = adr_i == OFS_CTRL2;
  assign hit_rate = adr_i == OFS_RATE;
  assign hit_status = adr_i == OFS_STATUS;
  assign hit_data = adr_i == OFS_DATA;

  assign port_en = ctrl1[BIT_PORT_EN];
  assign master = ctrl1[BIT_MASTER];
  assign clock_polarity_bit = ctrl1[BIT_CLOCK_POLARITY_BIT];
  assign clock_phase_bit = ctrl1[BIT_CLOCK_PHASE_BIT];
  assign irq_en = ctrl1[BIT_IRQ_EN];
  assign conflict_en = ctrl2[BIT_CONFLICT_EN];
  assign prescale = rate[POS_PRESCALE +: RATE_FIELD_W];
  assign power = rate[POS_POWER +: RATE_FIELD_W];

  // engine signals used by the register side
  logic mode_fault, xfer_done, load;
  logic [7:0] rx_word;

  // select seen low while master with detection on
  assign mode_fault = port_en && master && conflict_en && !ss_s;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // read mux, unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      dat_o <= 32'h0000_0000;
      if (hit_ctrl1) begin
        dat_o[7:0] <= ctrl1;
      end else if (hit_ctrl2) begin
        dat_o[7:0] <= ctrl2;
      end else if (hit_rate) begin
        dat_o[7:0] <= rate;
      end else if (hit_status) begin
        dat_o[BIT_RX_DONE] <= rx_flag;
        dat_o[BIT_TX_EMPTY] <= tx_empty;
        dat_o[BIT_CONFLICT] <= conflict_flag;
      end else if (hit_data) begin
        dat_o[7:0] <= rx_buf;
      end
    end
  end

  // first control register; a conflict forces slave mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl1 <= RST_CTRL1;
    end else if (mode_fault) begin
      ctrl1[BIT_MASTER] <= 1'b0;
    end else if (wr && hit_ctrl1) begin
      ctrl1 <= dat_i[7:0];
    end
  end

  // second control and rate registers; status writes go nowhere
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl2 <= RST_CTRL2;
      rate <= RST_RATE;
    end else begin
      if (wr && hit_ctrl2) begin
        ctrl2 <= dat_i[7:0];
      end
      if (wr && hit_rate) begin
        rate <= dat_i[7:0];
      end
    end
  end

  // receive flag and buffer; a finishing byte beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_flag <= 1'b0;
      rx_armed <= 1'b0;
      rx_buf <= RST_DATA;
    end else begin
      if (xfer_done && !rx_flag) begin
        rx_buf <= rx_word;
        rx_flag <= 1'b1;
      end else if (xfer_done) begin
        rx_flag <= 1'b1;
      end else if (rd && hit_data && rx_armed) begin
        rx_flag <= 1'b0;
      end
      if (rd && hit_status && rx_flag) begin
        rx_armed <= 1'b1;
      end else if (rd && hit_data) begin
        rx_armed <= 1'b0;
      end
    end
  end

  // transmit buffer, only an armed write is queued
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_empty <= 1'b1;
      tx_armed <= 1'b0;
      tx_buf <= RST_DATA;
    end else begin
      if (wr && hit_data && tx_armed && tx_empty) begin
        tx_buf <= dat_i[7:0];
        tx_empty <= 1'b0;
      end else if (load) begin
        tx_empty <= 1'b1;
      end
      if (rd && hit_status && tx_empty) begin
        tx_armed <= 1'b1;
      end else if (wr && hit_data) begin
        tx_armed <= 1'b0;
      end
    end
  end

  // conflict flag, set wins over the control write that clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conflict_flag <= 1'b0;
      conflict_armed <= 1'b0;
    end else begin
      if (mode_fault) begin
        conflict_flag <= 1'b1;
      end else if (wr && hit_ctrl1 && conflict_armed) begin
        conflict_flag <= 1'b0;
      end
      if (rd && hit_status && conflict_flag) begin
        conflict_armed <= 1'b1;
      end else if (wr && hit_ctrl1) begin
        conflict_armed <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine

  xfer_state_t state;
  logic [4:0] edge_cnt;
  logic [4:0] edge_num;
  logic [7:0] shreg;
  logic latched, tick, edge_ev, in_bit;
  logic sample_edge, shift_now, abort, last_edge;
  logic rate_change, fmt_change;

  // writes that must not disturb the far end mid-byte in master mode
  assign rate_change = wr && hit_rate && master && (dat_i[6:0] != rate[6:0]);
  assign fmt_change = wr && hit_ctrl1 && master &&
                      (dat_i[BIT_MASTER -: 3] != ctrl1[BIT_MASTER -: 3]);
  // slave aborts when deselected, anyone aborts when disabled
  assign abort = mode_fault || rate_change || fmt_change || !port_en ||
                 (!master && ss_s);

  rate_divider #(
    .PRE_W(RATE_FIELD_W),
    .POW_W(RATE_FIELD_W),
    .CNT_W(HALF_CNT_W)
  ) u_rate (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(master && port_en && (state != ST_IDLE)),
    .prescale_i(prescale),
    .power_i(power),
    .tick_o(tick)
  );

  // serial edges come from the divider as master, from the pin as slave
  assign edge_ev = master ? tick : ((sck_s ^ sck_d) && !ss_s);
  assign in_bit = master ? miso_s : mosi_s;
  assign edge_num = edge_cnt + 5'h01;
  assign last_edge = edge_num == 5'(EDGES_PER_BYTE);
  // phase picks odd or even edges for sampling; polarity plays no part here
  assign sample_edge = clock_phase_bit ? !edge_num[0] : edge_num[0];
  // with phase set the first edge only presents the first bit
  assign shift_now = (state == ST_RUN) && edge_ev && !sample_edge &&
                     !(clock_phase_bit && edge_num == 5'h01);
  assign xfer_done = (state == ST_RUN) && edge_ev && last_edge && !abort;
  // eight shifts exchange the byte with the far register
  assign rx_word = clock_phase_bit ? {shreg[6:0], in_bit} : {shreg[6:0], latched};
  assign load = (state == ST_IDLE) && !tx_empty && port_en;

  // state sequence; a queued byte restarts the engine at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      edge_cnt <= 5'h00;
    end else if (abort) begin
      state <= ST_IDLE;
      edge_cnt <= 5'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          edge_cnt <= 5'h00;
          if (master && load) begin
            state <= ST_LEAD;
          end else if (!master) begin
            state <= ST_RUN;
          end
        end
        ST_LEAD: begin
          // half a clock period here, so a full period from leaving idle to first edge
          if (tick) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (edge_ev && last_edge) begin
            state <= ST_IDLE;
            edge_cnt <= 5'h00;
          end else if (edge_ev) begin
            edge_cnt <= edge_num;
          end
        end
        default: begin
          state <= ST_IDLE;
          edge_cnt <= 5'h00;
        end
      endcase
    end
  end

  // shift register and its output bit move together, no pin lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shreg <= 8'h00;
      mosi_o <= 1'b0;
      latched <= 1'b0;
    end else begin
      if (load) begin
        shreg <= tx_buf;
        mosi_o <= tx_buf[BYTE_BITS-1];
      end else if (shift_now) begin
        shreg <= {shreg[6:0], latched};
        mosi_o <= shreg[6];
      end
      if ((state == ST_RUN) && edge_ev && sample_edge) begin
        latched <= in_bit;
      end
    end
  end

  assign miso_o = mosi_o;

  // serial clock rests at the polarity level and toggles per edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_o <= 1'b0;
    end else if (state != ST_RUN || !master || abort) begin
      sck_o <= clock_polarity_bit;
    end else if (tick) begin
      sck_o <= !sck_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin enables and interrupt

  // pins belong to the port only while enabled; conflicts release them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_oe_o <= 1'b0;
      mosi_oe_o <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      sck_oe_o <= port_en && master && !mode_fault;
      mosi_oe_o <= port_en && master && !mode_fault;
      miso_oe_o <= port_en && !master && !ss_s && !conflict_flag;
    end
  end

  // one level request for any set flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= irq_en && (rx_flag || tx_empty || conflict_flag);
    end
  end

endmodule

`default_nettype wire

// ---- include/spi_core_pkg.sv ----
// Purpose: shared constants for the byte-wide serial port core
// Assumes: 32-bit classic Wishbone, one aligned word per register
// Notes: register data sits in the low byte, upper bits read zero

package spi_core_pkg;

  // bus clock
  localparam int CLK_PERIOD_NS = 50;
  localparam int CLK_RATE_HZ = 1000000000 / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_RATE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DATA = 8'h10;

  // first_control_register fields
  localparam int BIT_IRQ_EN = 7;
  localparam int BIT_PORT_EN = 6;
  localparam int BIT_MASTER = 4;
  localparam int BIT_CLOCK_POLARITY_BIT = 3;
  localparam int BIT_CLOCK_PHASE_BIT = 2;

  // second_control_register fields
  localparam int BIT_CONFLICT_EN = 4;

  // rate register fields
  localparam int POS_PRESCALE = 4;
  localparam int POS_POWER = 0;
  localparam int RATE_FIELD_W = 3;

  // serial_port_status fields
  localparam int BIT_RX_DONE = 7;
  localparam int BIT_TX_EMPTY = 5;
  localparam int BIT_CONFLICT = 4;

  // reset values
  localparam logic [7:0] RST_CTRL1 = 8'h00;
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [7:0] RST_DATA = 8'h00;

  // transfer shape and divider range
  localparam int BYTE_BITS = 8;
  localparam int EDGES_PER_BYTE = 16;
  localparam int MAX_DIVISOR = 2048;
  localparam int HALF_CNT_W = 11;

  // transfer engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_RUN = 3'b100
  } xfer_state_t;

endpackage

// ---- design/rate_divider.sv ----
// Purpose: half-period tick generator for the master serial clock
// Assumes: tick period is (prescale+1) * 2^power bus cycles
// Notes: counting restarts whenever run_i falls

`timescale 1ns/1ns
`default_nettype none

module rate_divider
  import spi_core_pkg::*;
#(
  parameter int PRE_W = RATE_FIELD_W,
  parameter int POW_W = RATE_FIELD_W,
  parameter int CNT_W = HALF_CNT_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [PRE_W-1:0] prescale_i,
  input wire logic [POW_W-1:0] power_i,
  output logic tick_o
);

  // the largest half period must fit the counter
  if (CNT_W < PRE_W + (1 << POW_W) - 1) begin : g_bad_width
    $error("rate_divider: counter too narrow for divisor range");
  end

  logic [CNT_W-1:0] base;
  logic [CNT_W-1:0] limit;
  logic [CNT_W-1:0] cnt;

  // half period minus one, the full divisor is twice this plus two
  assign base = CNT_W'(prescale_i) + CNT_W'(1);
  assign limit = (base << power_i) - CNT_W'(1);

  // free count while running, one-cycle tick at each wrap
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (cnt == limit) begin
      cnt <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + CNT_W'(1);
      tick_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/spi_core_properties.sv ----
// Purpose: port-level checks for the serial port core
// Assumes: one bus clock, synchronous active-high reset
// Notes: control bits are shadowed from the bus writes seen at the ports

`timescale 1ns/1ns
`default_nettype none

module spi_core_properties
  import spi_core_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic ss_n_i,
  input wire logic sck_o,
  input wire logic sck_oe_o,
  input wire logic mosi_oe_o,
  input wire logic miso_oe_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic take, wr, rate_chg, clock_polarity_bit_q, irq_en_q, conf_en_q;
  logic [7:0] rate_q;

  // request taken at this edge
  assign take = cyc_i && stb_i && !ack_o;
  assign wr = take && we_i && sel_i[0];
  // only a real field change counts, rewriting the same value is no abort
  assign rate_chg = wr && adr_i == OFS_RATE &&
                    {dat_i[6:4], dat_i[2:0]} != {rate_q[6:4], rate_q[2:0]};

  // shadow copies, updated at the same edge the core applies a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_polarity_bit_q <= 1'b0;
      irq_en_q <= 1'b0;
      conf_en_q <= 1'b0;
      rate_q <= RST_RATE;
    end else if (wr) begin
      if (adr_i == OFS_CTRL1) begin
        clock_polarity_bit_q <= dat_i[BIT_CLOCK_POLARITY_BIT];
        irq_en_q <= dat_i[BIT_IRQ_EN];
      end
      if (adr_i == OFS_CTRL2) conf_en_q <= dat_i[BIT_CONFLICT_EN];
      if (adr_i == OFS_RATE) rate_q <= dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  property p_ack_next;
    take |=> ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no answer one cycle after request");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("answer held over one cycle");
  property p_status_bits;
    take && !we_i && adr_i == OFS_STATUS |=>
      dat_o[31:8] == 24'h0 && dat_o[6] == 1'b0 && dat_o[3:0] == 4'h0;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status shows unused bits");
  property p_unmapped;
    take && !we_i && adr_i > OFS_DATA |=> dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_oe_pair;
    mosi_oe_o == sck_oe_o;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock and data enables disagree");
  property p_oe_excl;
    sck_oe_o |-> !miso_oe_o;
  endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("master and slave outputs both on");
  property p_conflict;
    conf_en_q && sck_oe_o && !ss_n_i ##1 !ss_n_i [*2] |-> ##[0:4] !sck_oe_o;
  endproperty
  a_conflict: assert property (p_conflict) else $error("outputs kept after conflict");
  property p_rest_pol;
    $rose(sck_oe_o) |-> ##[0:1] sck_o == clock_polarity_bit_q;
  endproperty
  a_rest_pol: assert property (p_rest_pol) else $error("serial clock not at rest level");
  property p_irq_en;
    irq_o |-> $past(irq_en_q);
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("request while disabled");
  property p_rate_abort;
    rate_chg && sck_oe_o |-> ##[1:3] sck_o == clock_polarity_bit_q;
  endproperty
  a_rate_abort: assert property (p_rate_abort) else $error("rate change kept clock");

  c_data_wr: cover property (take && we_i && adr_i == OFS_DATA);
  c_conflict: cover property (conf_en_q && !ss_n_i && sck_oe_o);
  c_rate_abort: cover property (rate_chg && sck_oe_o);
endmodule

bind spi_status_data_core spi_core_properties chk (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .ss_n_i(ss_n_i), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
  .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o), .irq_o(irq_o));

`default_nettype wire

// ---- testbench/spi_peer_model.sv ----
// Purpose: behavioural serial slave facing the core in master mode
// Assumes: selected by the bench, msb first, 16 data bits per selection
// Notes: a released data line shows the inverse of its last level

`timescale 1ns/1ns
`default_nettype none

module spi_peer_model (
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  input wire logic clock_phase_bit_i,
  input wire logic [15:0] tx_i,
  output var logic miso_o,
  output var logic [15:0] rx_o
);
  int edge_n;
  int bit_n;

  initial begin
    miso_o = 1'b0;
    rx_o = 16'h0000;
  end

  // fresh frame at each selection; phase 0 shows the first bit at once
  always @(negedge sel_n_i) begin
    edge_n = 0;
    bit_n = 15;
    if (!clock_phase_bit_i) begin
      miso_o = tx_i[15];
      bit_n = 14;
    end
  end

  // never leave the last value standing once released
  always @(posedge sel_n_i) miso_o = ~miso_o;

  // sample on odd or even edges by phase, drive on the others
  always @(sck_i) begin
    if (sel_n_i === 1'b0) begin
      edge_n++;
      if (edge_n[0] != clock_phase_bit_i) begin
        rx_o = {rx_o[14:0], mosi_i};
      end else if (bit_n >= 0) begin
        miso_o = tx_i[bit_n];
        bit_n--;
      end
    end
  end
endmodule

`default_nettype wire

// ---- testbench/spi_status_data_core_tb.sv ----
// Purpose: self-checking bench for the serial port core
// Assumes: classic single-cycle bus master, peer slave model on the pins
// Notes: serial half period is measured from the clock pin itself

`timescale 1ns/1ns
`default_nettype none

module spi_status_data_core_tb
  import spi_core_pkg::*;
;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ss_n_i, sck_tb, mosi_tb, clock_polarity_bit, clock_phase_bit, ps_sel_n;
  logic [7:0] adr_i;
  logic [31:0] dat_i, q;
  logic [15:0] ps_tx;
  wire logic [31:0] dat_o;
  wire logic [15:0] ps_rx;
  wire logic ack_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, irq_o, ps_miso;
  wire logic sck_w, mosi_w, miso_w;
  int err_count, checks, run, half_len, n;

  // pin levels resolved from every driver's enable
  assign sck_w = sck_oe_o ? sck_o : sck_tb;
  assign mosi_w = mosi_oe_o ? mosi_o : mosi_tb;
  assign miso_w = miso_oe_o ? miso_o : ps_miso;

  spi_status_data_core uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ss_n_i(ss_n_i), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_o(miso_oe_o), .irq_o(irq_o));
  spi_peer_model peer (.sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(ps_sel_n), .clock_phase_bit_i(clock_phase_bit),
    .tx_i(ps_tx), .miso_o(ps_miso), .rx_o(ps_rx));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // cycles between serial clock toggles; one process so the count never races
  logic sck_q;
  always @(posedge clk_i) begin
    run++;
    if (sck_o !== sck_q) begin
      half_len = run;
      run = 0;
    end
    sck_q = sck_o;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task stall;
    err_count++;
    report_and_stop;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one classic cycle: hold until ack is sampled, then release a cycle
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
    if (n >= 20) stall;
  endtask
  // polling status also arms the receive clear
  task wait_rx;
    int k;
    k = 0;
    q = 32'h0;
    while (q[BIT_RX_DONE] !== 1'b1 && k < 9000) begin
      bus(1'b0, OFS_STATUS, 8'h00);
      k++;
    end
    if (k >= 9000) stall;
  endtask
  task wait_idle;
    int k;
    k = 0;
    while (run < 40 && k < 5000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 5000) stall;
  endtask
  task finish_byte(input logic [7:0] pb, input logic [7:0] db);
    wait_rx;
    ps_sel_n <= 1'b1;
    bus(1'b0, OFS_DATA, 8'h00);
    chk(q, {24'h0, pb});
    chk({24'h0, ps_rx[7:0]}, {24'h0, db});
    bus(1'b0, OFS_STATUS, 8'h00);
    chk({31'h0, q[BIT_RX_DONE]}, 32'h0);
  endtask
  task xfer(input logic [1:0] md, input logic [7:0] db, input logic [7:0] pb);
    bus(1'b1, OFS_CTRL1, {3'b010, 1'b1, md, 2'b00});
    clock_polarity_bit <= md[1];
    clock_phase_bit <= md[0];
    ps_tx <= {pb, 8'h00};
    @(posedge clk_i);
    ps_sel_n <= 1'b0;
    bus(1'b0, OFS_STATUS, 8'h00);
    bus(1'b1, OFS_DATA, db);
    finish_byte(pb, db);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // queue discipline and the status register with the port off
  task t_queue;
    bus(1'b1, OFS_DATA, 8'h5A);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk(q, 32'h20);
    bus(1'b1, OFS_DATA, 8'hA5);
    bus(1'b1, OFS_STATUS, 8'hFF);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk(q, 32'h00);
    bus(1'b1, OFS_DATA, 8'h11);
    bus(1'b0, 8'h20, 8'h00);
    chk(q, 32'h0);
    bus(1'b1, OFS_RATE, 8'h02);
    ps_tx <= 16'h6C00;
    ps_sel_n <= 1'b0;
    bus(1'b1, OFS_CTRL1, 8'h50);
    finish_byte(8'h6C, 8'hA5);
  endtask
  // unserviced flag: second byte lost, first kept
  task t_overrun;
    bus(1'b1, OFS_CTRL1, 8'h50);
    clock_phase_bit <= 1'b0;
    ps_tx <= 16'hC33C;
    @(posedge clk_i);
    ps_sel_n <= 1'b0;
    bus(1'b0, OFS_STATUS, 8'h00);
    bus(1'b1, OFS_DATA, 8'h81);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk({31'h0, q[BIT_TX_EMPTY]}, 32'h1);
    bus(1'b1, OFS_DATA, 8'h7E);
    wait_rx;
    wait_idle;
    ps_sel_n <= 1'b1;
    chk({16'h0, ps_rx}, 32'h817E);
    bus(1'b0, OFS_STATUS, 8'h00);
    bus(1'b0, OFS_DATA, 8'h00);
    chk(q, 32'hC3);
  endtask
  task t_rate_abort;
    ps_sel_n <= 1'b0;
    bus(1'b0, OFS_STATUS, 8'h00);
    bus(1'b1, OFS_DATA, 8'h99);
    repeat (20) @(posedge clk_i);
    bus(1'b1, OFS_RATE, 8'h03);
    wait_idle;
    ps_sel_n <= 1'b1;
    bus(1'b0, OFS_STATUS, 8'h00);
    chk(q, 32'h20);
  endtask
  task t_conflict;
    bus(1'b1, OFS_CTRL2, 8'h10);
    bus(1'b1, OFS_CTRL1, 8'hD0);
    chk({31'h0, irq_o}, 32'h1);
    ss_n_i <= 1'b0;
    n = 0;
    while (sck_oe_o !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20) stall;
    bus(1'b0, OFS_STATUS, 8'h00);
    chk(q, 32'h30);
    bus(1'b0, OFS_CTRL1, 8'h00);
    chk(q, 32'hC0);
    chk({31'h0, mosi_oe_o}, 32'h0);
    ss_n_i <= 1'b1;
    bus(1'b1, OFS_CTRL1, 8'h00);
    bus(1'b0, OFS_STATUS, 8'h00);
    chk(q, 32'h20);
    bus(1'b1, OFS_CTRL1, 8'h40);
    ss_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk({30'h0, miso_oe_o, sck_oe_o}, 32'h2);
    ss_n_i <= 1'b1;
  endtask
  // slave byte clocked by the bench, phase 0, six bus cycles per half period
  task t_slave(input logic [7:0] sb, input logic [7:0] st);
    logic [7:0] got;
    bus(1'b0, OFS_STATUS, 8'h00);
    bus(1'b1, OFS_DATA, st);
    ss_n_i <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_tb <= sb[i];
      repeat (6) @(posedge clk_i);
      got[i] = miso_w;
      sck_tb <= 1'b1;
      repeat (6) @(posedge clk_i);
      sck_tb <= 1'b0;
    end
    wait_rx;
    ss_n_i <= 1'b1;
    bus(1'b0, OFS_DATA, 8'h00);
    chk(q, {24'h0, sb});
    chk({24'h0, got}, {24'h0, st});
  endtask

  initial begin
    {cyc_i, stb_i, we_i, sck_tb, mosi_tb, clock_polarity_bit, clock_phase_bit} = 7'h00;
    {ss_n_i, ps_sel_n, rst_i} = 3'b111;
    adr_i = 8'h00;
    dat_i = 32'h0;
    ps_tx = 16'h0000;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_queue;
    for (int m = 0; m < 4; m++) xfer(m[1:0], 8'h96 ^ m[7:0], 8'h3C + m[7:0]);
    chk(half_len, 32'd4);
    bus(1'b1, OFS_RATE, 8'h77);
    xfer(2'b00, 8'h0F, 8'hF0);
    chk(half_len, 32'd1024);
    bus(1'b1, OFS_RATE, 8'h02);
    t_overrun;
    t_rate_abort;
    t_conflict;
    t_slave(8'h2D, 8'hB4);
    report_and_stop;
  end
endmodule

`default_nettype wire
